// file: cld_map.svh
`ifndef CLD_MAP_SVH
`define CLD_MAP_SVH

// register byte offsets
`define CLD_OFF_CTRL     7'h00
`define CLD_OFF_STATUS   7'h04
`define CLD_OFF_PIN_IN   7'h08
`define CLD_OFF_PIN_OUT  7'h0c
`define CLD_OFF_PIN_EN   7'h10
`define CLD_OFF_T1_LO    7'h14
`define CLD_OFF_T1_HI    7'h18
`define CLD_OFF_CLK_DIV  7'h1c
`define CLD_OFF_EVENT    7'h20
`define CLD_OFF_T2_LO    7'h2c
`define CLD_OFF_T2_HI    7'h30
`define CLD_OFF_FIFO     7'h34

// loader_control fields
`define CLD_CTRL_W       5
`define CLD_CTRL_SEND    3
`define CLD_CTRL_VENDOR  4

// pin bit positions
`define CLD_PIN_CLK      0
`define CLD_PIN_DATA     1
`define CLD_PIN_START    2
`define CLD_PIN_PULLUP   3
`define CLD_IN_DONE      0
`define CLD_IN_STATUS    1

// event bit positions
`define CLD_EV_READY     0
`define CLD_EV_UNDER     1
`define CLD_EV_DONE      2
`define CLD_EV_ERROR     3

// reset values
`define CLD_RST_CTRL     5'h00
`define CLD_RST_PIN      4'h0
`define CLD_RST_DIV      16'h0000
`define CLD_RST_TIMER    32'h0000_0000

`endif

// file: cld_pkg.sv
`default_nettype none
package cld_pkg;
	typedef enum logic [2:0]
	{
		CLD_MODE_GPIO = 3'h0,
		CLD_MODE_FIFO = 3'h2,
		CLD_MODE_FSM  = 3'h7
	} cld_mode_t;

	typedef enum logic [2:0]
	{
		CLD_S_IDLE,
		CLD_S_PULSE,
		CLD_S_WAIT_RDY,
		CLD_S_DELAY,
		CLD_S_DATA,
		CLD_S_DONE,
		CLD_S_ERR
	} cld_state_t;

	typedef logic [31:0] cld_word_t;
endpackage
`default_nettype wire

// file: cld_tick.sv
`default_nettype none
module cld_tick #(
	parameter int W = 16
) (
	input  wire logic         clk_i,   // bus clock
	input  wire logic         reset_i, // sync reset
	input  wire logic [W-1:0] div_i,   // period minus one
	output var  logic         tick_o   // one-cycle tick
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge clk_i)
	begin
		if (reset_i || cnt_r >= div_i)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + W'(1);
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			tick_o <= 1'b0;
		else
			tick_o <= (cnt_r >= div_i);
	end

	tick_period_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		tick_o |-> $past(cnt_r) >= $past(div_i))
		else $error("tick without full divider count");
endmodule
`default_nettype wire

// file: cld_fifo.sv
`default_nettype none
module cld_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic         clk_i,   // bus clock
	input  wire logic         reset_i, // sync reset
	input  wire logic         push_i,  // write strobe
	input  wire logic [W-1:0] wdata_i, // write word
	input  wire logic         pop_i,   // read strobe
	output logic      [W-1:0] rdata_o, // head word
	output logic              full_o,  // no room
	output logic              empty_o  // no data
);
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          do_push;
	logic          do_pop;

	assign full_o  = (cnt_r == (AW+1)'(DEPTH));
	assign empty_o = (cnt_r == '0);
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;
	assign rdata_o = mem_r[rp_r];

	always_ff @(posedge clk_i)
	begin
		if (do_push)
			mem_r[wp_r] <= wdata_i;
	end

	// depth must be a power of two so the pointers wrap by themselves
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r  <= wp_r + AW'(do_push);
			rp_r  <= rp_r + AW'(do_pop);
			cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	fifo_count_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		push_i && !full_o && !pop_i |=> cnt_r == $past(cnt_r) + 1)
		else $error("fifo count did not follow push");
endmodule
`default_nettype wire

// file: cld_loader.sv
// The Avalon-MM register port and the address map were decided locally.
`include "cld_map.svh"
`default_nettype none
module cld_loader #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic                clk_i,                  // 40 MHz
	input  wire logic                reset_i,                // sync, high
	input  wire logic [6:0]          avs_address_i,          // byte addr
	input  wire logic                avs_read_i,             // read
	input  wire logic                avs_write_i,            // write
	input  wire cld_pkg::cld_word_t  avs_writedata_i,        // wdata
	input  wire logic [3:0]          avs_byteenable_i,       // lanes
	output var  cld_pkg::cld_word_t  avs_readdata_o,         // rdata
	output var  logic                avs_waitrequest_o,      // stall
	input  wire logic                boot_vendor_load_i,     // boot strobe
	input  wire logic                boot_vendor_i,          // boot vendor
	input  wire logic                config_complete_in_i,   // done pin
	input  wire logic                init_status_in_i,       // status pin
	output var  logic                serial_config_clock_o,  // clock
	output logic                     serial_config_clock_oe_o,
	output var  logic                serial_config_bit_o,    // data
	output logic                     serial_config_bit_oe_o,
	output var  logic                config_start_pulse_o,   // start
	output logic                     config_start_pulse_oe_o,
	output var  logic                pullup_control_out_o,   // pull-up
	output logic                     pullup_control_out_oe_o
);
	import cld_pkg::*;

	logic [`CLD_CTRL_W-1:0] ctrl_r;
	logic [3:0]  pin_out_r;
	logic [3:0]  pin_en_r;
	logic [1:0]  pin_in_r;
	logic        stat_q_r;
	logic [31:0] t1_r;
	logic [31:0] t2_r;
	logic [15:0] div_r;
	logic [3:0]  evt_r;
	logic [3:0]  evt_set;
	logic [3:0]  evt_clr;
	cld_state_t  state_r;
	logic [31:0] tcnt_r;
	logic        fsm_start_r;
	logic        tick;
	logic        req;
	logic        stall;
	logic        acc_wr;
	logic [6:0]  addr;
	cld_word_t   wmrg;
	cld_word_t   rd_nxt;
	cld_word_t   fifo_rdata;
	logic        fifo_full;
	logic        fifo_empty;
	logic        fifo_push;
	logic        fifo_pop;
	logic [30:0] shift_r;
	logic [4:0]  bits_r;
	logic        have_r;
	logic        sclk_r;
	logic        sdata_r;
	logic        under_r;
	logic        eng_run;
	logic        fsm_go;
	logic        stat_rise;
	cld_mode_t   mode;

	function automatic cld_word_t cld_merge(input cld_word_t o,
		input cld_word_t w, input logic [3:0] be);
		cld_word_t m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (o & ~m) | (w & m);
	endfunction

	assign addr   = {avs_address_i[6:2], 2'b00};
	assign req    = avs_read_i || avs_write_i;
	// a full FIFO holds the bus so no bitstream word is dropped
	assign stall  = avs_write_i && addr == `CLD_OFF_FIFO && fifo_full;
	assign acc_wr = avs_write_i && !avs_waitrequest_o;
	assign mode   = cld_mode_t'(ctrl_r[2:0]);
	assign fsm_go = acc_wr && addr == `CLD_OFF_CTRL && avs_byteenable_i[0]
		&& avs_writedata_i[2:0] == CLD_MODE_FSM;
	assign stat_rise = pin_in_r[`CLD_IN_STATUS] && !stat_q_r;

	// bus slave: one wait cycle, then a one-cycle answer
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			avs_waitrequest_o <= 1'b1;
		else
			avs_waitrequest_o <= !(req && avs_waitrequest_o && !stall);
	end

	always_comb
	begin
		wmrg = cld_merge(32'h0, avs_writedata_i, avs_byteenable_i);
		case (addr)
			`CLD_OFF_CTRL:    rd_nxt = 32'(ctrl_r);
			`CLD_OFF_STATUS:  rd_nxt = {21'h0, 3'(state_r), 1'b0,
				fifo_full, fifo_empty, under_r,
				ctrl_r[`CLD_CTRL_VENDOR] && !pin_in_r[`CLD_IN_STATUS],
				!ctrl_r[`CLD_CTRL_VENDOR] && pin_in_r[`CLD_IN_STATUS],
				pin_in_r};
			`CLD_OFF_PIN_IN:  rd_nxt = {30'h0, pin_in_r};
			`CLD_OFF_PIN_OUT: rd_nxt = {28'h0, pin_out_r};
			`CLD_OFF_PIN_EN:  rd_nxt = {28'h0, pin_en_r};
			`CLD_OFF_T1_LO:   rd_nxt = {16'h0, t1_r[15:0]};
			`CLD_OFF_T1_HI:   rd_nxt = {16'h0, t1_r[31:16]};
			`CLD_OFF_T2_LO:   rd_nxt = {16'h0, t2_r[15:0]};
			`CLD_OFF_T2_HI:   rd_nxt = {16'h0, t2_r[31:16]};
			`CLD_OFF_CLK_DIV: rd_nxt = {16'h0, div_r};
			`CLD_OFF_EVENT:   rd_nxt = {28'h0, evt_r};
			default:          rd_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			avs_readdata_o <= 32'h0;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= rd_nxt;
	end

	// software registers; boot load only touches the vendor bit
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			ctrl_r <= `CLD_RST_CTRL;
		else if (acc_wr && addr == `CLD_OFF_CTRL)
			ctrl_r <= wmrg[`CLD_CTRL_W-1:0] |
				(ctrl_r & ~{`CLD_CTRL_W{avs_byteenable_i[0]}});
		else if (boot_vendor_load_i)
			ctrl_r[`CLD_CTRL_VENDOR] <= boot_vendor_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pin_out_r <= `CLD_RST_PIN;
			pin_en_r  <= `CLD_RST_PIN;
			div_r     <= `CLD_RST_DIV;
		end
		else if (acc_wr)
		begin
			if (addr == `CLD_OFF_PIN_OUT && avs_byteenable_i[0])
				pin_out_r <= avs_writedata_i[3:0];
			if (addr == `CLD_OFF_PIN_EN && avs_byteenable_i[0])
				pin_en_r <= avs_writedata_i[3:0];
			if (addr == `CLD_OFF_CLK_DIV)
				div_r <= wmrg[15:0] | (div_r
					& ~{{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}});
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			t1_r <= `CLD_RST_TIMER;
			t2_r <= `CLD_RST_TIMER;
		end
		else if (acc_wr)
		begin
			if (addr == `CLD_OFF_T1_LO)
				t1_r[15:0] <= wmrg[15:0] | (t1_r[15:0]
					& ~{{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}});
			if (addr == `CLD_OFF_T1_HI)
				t1_r[31:16] <= wmrg[15:0] | (t1_r[31:16]
					& ~{{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}});
			if (addr == `CLD_OFF_T2_LO)
				t2_r[15:0] <= wmrg[15:0] | (t2_r[15:0]
					& ~{{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}});
			if (addr == `CLD_OFF_T2_HI)
				t2_r[31:16] <= wmrg[15:0] | (t2_r[31:16]
					& ~{{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}});
		end
	end

	// sticky events, write one to clear; a new event beats the clear
	assign evt_clr = (acc_wr && addr == `CLD_OFF_EVENT) ? wmrg[3:0] : 4'h0;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			evt_r <= 4'h0;
		else
			evt_r <= (evt_r & ~evt_clr) | evt_set;
	end

	// pins sampled every cycle in all modes
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pin_in_r <= 2'b00;
			stat_q_r <= 1'b0;
		end
		else
		begin
			pin_in_r <= {init_status_in_i, config_complete_in_i};
			stat_q_r <= pin_in_r[`CLD_IN_STATUS];
		end
	end

	cld_tick #(
		.W(16)
	) u_tick (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.div_i   (div_r),
		.tick_o  (tick)
	);

	assign fifo_push = acc_wr && addr == `CLD_OFF_FIFO;

	cld_fifo #(
		.W(32),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.push_i  (fifo_push),
		.wdata_i (avs_writedata_i),
		.pop_i   (fifo_pop),
		.rdata_o (fifo_rdata),
		.full_o  (fifo_full),
		.empty_o (fifo_empty)
	);

	// the engine stops on done; before that it runs only with the send bit in FIFO mode or in CLD_S_DATA, and pauses while the FIFO is empty
	assign eng_run = !pin_in_r[`CLD_IN_DONE] &&
		((mode == CLD_MODE_FIFO && ctrl_r[`CLD_CTRL_SEND]) ||
		(mode == CLD_MODE_FSM && state_r == CLD_S_DATA));
	assign fifo_pop = eng_run && tick && !sclk_r && !have_r
		&& bits_r == 5'h0 && !fifo_empty;

	// serialiser: data is placed one tick after the falling edge and
	// the clock rises one tick later, so data never moves near a rise
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !eng_run)
		begin
			sclk_r  <= 1'b0;
			have_r  <= 1'b0;
			bits_r  <= 5'h0;
			shift_r <= 31'h0;
			sdata_r <= 1'b0;
			under_r <= 1'b0;
		end
		else if (tick)
		begin
			if (sclk_r)
			begin
				sclk_r <= 1'b0;
				have_r <= 1'b0;
			end
			else if (have_r)
				sclk_r <= 1'b1;
			else if (bits_r != 5'h0)
			begin
				sdata_r <= shift_r[30];
				shift_r <= {shift_r[29:0], 1'b0};
				bits_r  <= bits_r - 5'h1;
				have_r  <= 1'b1;
			end
			else if (!fifo_empty)
			begin
				sdata_r <= fifo_rdata[31];
				shift_r <= fifo_rdata[30:0];
				bits_r  <= 5'h1f;
				have_r  <= 1'b1;
				under_r <= 1'b0;
			end
			else
				under_r <= 1'b1;
		end
	end

	// configuration sequence, identical for both vendors
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_r     <= CLD_S_IDLE;
			tcnt_r      <= 32'h0;
			fsm_start_r <= 1'b1;
		end
		else if (fsm_go)
		begin
			state_r     <= CLD_S_PULSE;
			tcnt_r      <= 32'h0;
			fsm_start_r <= 1'b0;
		end
		else if (mode != CLD_MODE_FSM)
		begin
			state_r     <= CLD_S_IDLE;
			fsm_start_r <= 1'b1;
		end
		else
		begin
			case (state_r)
				CLD_S_PULSE:
					if (tick)
					begin
						tcnt_r <= tcnt_r + 32'h1;
						if (tcnt_r + 32'h1 >= t1_r)
						begin
							fsm_start_r <= 1'b1;
							state_r     <= CLD_S_WAIT_RDY;
						end
					end
				CLD_S_WAIT_RDY:
					if (stat_rise)
					begin
						tcnt_r  <= 32'h0;
						state_r <= CLD_S_DELAY;
					end
				CLD_S_DELAY:
					if (tick)
					begin
						tcnt_r <= tcnt_r + 32'h1;
						if (tcnt_r + 32'h1 >= t2_r)
							state_r <= CLD_S_DATA;
					end
				CLD_S_DATA:
					if (pin_in_r[`CLD_IN_DONE])
						state_r <= CLD_S_DONE;
					else if (!pin_in_r[`CLD_IN_STATUS])
						state_r <= CLD_S_ERR;
				CLD_S_IDLE,
				CLD_S_DONE,
				CLD_S_ERR:
					state_r <= state_r;
				default:
					state_r <= CLD_S_IDLE;
			endcase
		end
	end

	always_comb
	begin
		evt_set = 4'h0;
		evt_set[`CLD_EV_READY] = stat_rise;
		evt_set[`CLD_EV_UNDER] = eng_run && tick && !sclk_r && !have_r
			&& bits_r == 5'h0 && fifo_empty && !under_r;
		evt_set[`CLD_EV_DONE] = mode == CLD_MODE_FSM && !fsm_go
			&& state_r == CLD_S_DATA && pin_in_r[`CLD_IN_DONE];
		evt_set[`CLD_EV_ERROR] = mode == CLD_MODE_FSM && !fsm_go
			&& state_r == CLD_S_DATA && !pin_in_r[`CLD_IN_DONE]
			&& !pin_in_r[`CLD_IN_STATUS];
	end

	// pin drivers: engine owns clock and data in FIFO and FSM modes only
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			serial_config_clock_o <= 1'b0;
			serial_config_bit_o   <= 1'b0;
			config_start_pulse_o  <= 1'b0;
			pullup_control_out_o  <= 1'b0;
		end
		else
		begin
			serial_config_clock_o <= (mode == CLD_MODE_FIFO ||
				mode == CLD_MODE_FSM) ? sclk_r
				: pin_out_r[`CLD_PIN_CLK];
			serial_config_bit_o <= (mode == CLD_MODE_FIFO ||
				mode == CLD_MODE_FSM) ? sdata_r
				: pin_out_r[`CLD_PIN_DATA];
			config_start_pulse_o <= (mode == CLD_MODE_FSM) ? fsm_start_r
				: pin_out_r[`CLD_PIN_START];
			pullup_control_out_o <= pin_out_r[`CLD_PIN_PULLUP];
		end
	end

	assign serial_config_clock_oe_o = pin_en_r[`CLD_PIN_CLK];
	assign serial_config_bit_oe_o   = pin_en_r[`CLD_PIN_DATA];
	assign config_start_pulse_oe_o  = pin_en_r[`CLD_PIN_START];
	assign pullup_control_out_oe_o  = pin_en_r[`CLD_PIN_PULLUP];

	gpio_pin_follow_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		mode == CLD_MODE_GPIO |=> serial_config_clock_o
		== $past(pin_out_r[`CLD_PIN_CLK]))
		else $error("bit-bang clock pin not from register");
	// one tick of setup is all the divider promises when it is zero
	data_at_rise_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		$rose(sclk_r) |-> $stable(sdata_r))
		else $error("data moved at clock rise");
	underflow_clock_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		under_r && $past(under_r) |-> !sclk_r)
		else $error("clock runs during underflow");
	underflow_event_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		$rose(under_r) |-> evt_r[`CLD_EV_UNDER])
		else $error("underflow event missing");
	start_low_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		fsm_go ##1 mode == CLD_MODE_FSM ##1 mode == CLD_MODE_FSM
		|-> !config_start_pulse_o)
		else $error("start pulse not driven low");
	done_event_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		evt_set[`CLD_EV_DONE] |=> state_r == CLD_S_DONE
		&& evt_r[`CLD_EV_DONE])
		else $error("done not recorded");
	event_set_wins_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		evt_set[`CLD_EV_READY] && evt_clr[`CLD_EV_READY]
		|=> evt_r[`CLD_EV_READY])
		else $error("event lost to clear");
	bus_answer_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer longer than one cycle");
	no_clock_after_done_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		pin_in_r[`CLD_IN_DONE] |=> !sclk_r)
		else $error("clock after done");
endmodule
`default_nettype wire

// file: cld_tick_unused_guard.sv
`default_nettype none
`default_nettype wire

// file: cld_fpga_model.sv
`default_nettype none
module cld_fpga_model #(
	parameter int READY_CYC = 8,
	parameter int DONE_BITS = 64
) (
	input  wire logic        clk_i,    // bus clock
	input  wire logic        reset_i,  // sync reset
	input  wire logic        sclk_i,   // serial clock pin
	input  wire logic        sdat_i,   // serial data pin
	input  wire logic        start_i,  // start pin level
	input  wire logic        err_i,    // bench-commanded error
	output var  logic        done_o,   // complete pin
	output var  logic        status_o, // status pin
	output var  logic [31:0] word_o,   // last whole word
	output var  logic        word_v_o, // word strobe
	output var  logic        fault_o   // data moved at a rising edge
);
	logic        sclk_q;
	logic        sdat_q;
	logic [31:0] sh;
	int          bits;
	int          rdy;
	wire         rise = sclk_i && !sclk_q;

	always_ff @(posedge clk_i)
	begin
		sclk_q <= sclk_i;
		sdat_q <= sdat_i;
		word_v_o <= 1'b0;
		// a low start clears the whole configuration, as a real target does
		if (reset_i || !start_i)
		begin
			rdy <= 0;
			bits <= 0;
			done_o <= 1'b0;
			status_o <= 1'b0;
		end
		else
		begin
			if (rdy < READY_CYC)
				rdy <= rdy + 1;
			status_o <= (rdy >= READY_CYC) && !err_i;
			if (rise && status_o && !done_o)
			begin
				sh <= {sh[30:0], sdat_i};
				bits <= bits + 1;
				if (bits % 32 == 31)
					word_o <= {sh[30:0], sdat_i};
				word_v_o <= (bits % 32 == 31);
				if (bits + 1 == DONE_BITS)
					done_o <= 1'b1;
			end
		end
		if (reset_i)
			fault_o <= 1'b0;
		else if (rise && sdat_i != sdat_q)
			fault_o <= 1'b1;
	end
endmodule
`default_nettype wire

// file: cld_loader_tb.sv
`include "cld_map.svh"
`default_nettype none
module cld_loader_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cld_pkg::*;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [6:0]  adr = '0;
	logic        rreq = 1'b0;
	logic        wreq = 1'b0;
	cld_word_t   wdat = '0;
	logic        load = 1'b0;
	logic        vend = 1'b0;
	logic        err = 1'b0;
	cld_word_t   rdata;
	logic        wait_r;
	logic        sck, sck_oe, sdo, sdo_oe, stp, stp_oe, pu, pu_oe;
	logic        done, status, wv, fault;
	cld_word_t   word;
	cld_word_t   rq_e[$], rq_m[$], wq[$];
	int          miscompares = 0;
	int          samples_checked = 0;
	int          n, c, div;
	cld_word_t   w;

	always #12.5 clk_i = !clk_i;

	cld_loader #(.FIFO_DEPTH(16)) dut_u (
		.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
		.avs_read_i(rreq), .avs_write_i(wreq), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_r), .boot_vendor_load_i(load),
		.boot_vendor_i(vend), .config_complete_in_i(done),
		.init_status_in_i(status), .serial_config_clock_o(sck),
		.serial_config_clock_oe_o(sck_oe), .serial_config_bit_o(sdo),
		.serial_config_bit_oe_o(sdo_oe), .config_start_pulse_o(stp),
		.config_start_pulse_oe_o(stp_oe), .pullup_control_out_o(pu),
		.pullup_control_out_oe_o(pu_oe));

	// start line is pulled up on the target side when not driven
	cld_fpga_model fpga_u (
		.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sck), .sdat_i(sdo),
		.start_i(stp_oe ? stp : 1'b1), .err_i(err), .done_o(done),
		.status_o(status), .word_o(word), .word_v_o(wv), .fault_o(fault));

	task automatic check(input string nm, input cld_word_t seen,
		input cld_word_t exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// waits as long as the slave stalls; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [6:0] a, input cld_word_t d);
		@(posedge clk_i);
		adr <= a;
		wdat <= d;
		wreq <= wr;
		rreq <= !wr;
		do
			@(posedge clk_i);
		while (wait_r !== 1'b0);
		wreq <= 1'b0;
		rreq <= 1'b0;
	endtask

	task automatic wr(input logic [6:0] a, input cld_word_t d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [6:0] a, input cld_word_t e, input cld_word_t m);
		rq_e.push_back(e);
		rq_m.push_back(m);
		bus(1'b0, a, '0);
	endtask

	task automatic push_word();
		w = $urandom;
		wq.push_back(w);
		wr(`CLD_OFF_FIFO, w);
	endtask

	task automatic drain();
		for (n = 0; n < 3000 && wq.size() != 0; n++) @(posedge clk_i);
		check("words left", 32'(wq.size()), 32'h0);
		repeat (12) @(posedge clk_i);
	endtask

	// results are matched against the oldest note as they appear
	always @(posedge clk_i)
	begin
		if (rreq && wait_r === 1'b0)
			check("readdata", rdata & rq_m[0], rq_e.pop_front());
		if (rreq && wait_r === 1'b0)
			void'(rq_m.pop_front());
		if (wv === 1'b1)
			check("serial word", word, wq.pop_front());
	end

	initial
	begin
		#500000;
		miscompares++;
		close_out();
	end

	initial
	begin
		void'($urandom(32'h4c54));
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(`CLD_OFF_CTRL, 32'h0, 32'h1f);
		rd(`CLD_OFF_PIN_EN, 32'h0, 32'hf);
		rd(`CLD_OFF_CLK_DIV, 32'h0, 32'hffff);
		wr(7'h24, 32'hffff_ffff);
		rd(7'h24, 32'h0, 32'hffff_ffff);
		@(posedge clk_i);
		vend <= 1'b1;
		load <= 1'b1;
		@(posedge clk_i);
		load <= 1'b0;
		rd(`CLD_OFF_CTRL, 32'h10, 32'h10);
		wr(`CLD_OFF_CTRL, 32'h0);
		$display("test reset_vendor done");

		wr(`CLD_OFF_PIN_EN, 32'hf);
		for (c = 0; c < 2; c++)
		begin
			w = c ? 32'h2 : 32'hd;
			wr(`CLD_OFF_PIN_OUT, w);
			repeat (2) @(posedge clk_i);
			check("pins", {28'h0, pu, stp, sdo, sck}, w);
			check("enables", {28'h0, pu_oe, stp_oe, sdo_oe, sck_oe}, 32'hf);
		end
		rd(`CLD_OFF_PIN_IN, 32'h0, 32'h3);
		wr(`CLD_OFF_PIN_OUT, 32'h4);
		repeat (20) @(posedge clk_i);
		rd(`CLD_OFF_PIN_IN, 32'h2, 32'h3);
		rd(`CLD_OFF_EVENT, 32'h1, 32'h1);
		$display("test bit_bang done");

		div = $urandom_range(2);
		wr(`CLD_OFF_CLK_DIV, 32'(div));
		push_word();
		wr(`CLD_OFF_CTRL, 32'ha);
		drain();
		check("idle clock", {31'h0, sck}, 32'h0);
		rd(`CLD_OFF_STATUS, 32'h10, 32'h10);
		rd(`CLD_OFF_EVENT, 32'h2, 32'h2);
		push_word();
		drain();
		rd(`CLD_OFF_STATUS, 32'h1, 32'h1);
		$display("test fifo_underflow done");

		wr(`CLD_OFF_CTRL, 32'h0);
		wr(`CLD_OFF_T1_LO, 32'h3);
		wr(`CLD_OFF_T1_HI, 32'h0);
		wr(`CLD_OFF_T2_LO, 32'h14);
		wr(`CLD_OFF_T2_HI, 32'h0);
		rd(`CLD_OFF_T2_LO, 32'h14, 32'hffff);
		push_word();
		push_word();
		wr(`CLD_OFF_CTRL, 32'h7);
		for (n = 0; n < 200 && stp !== 1'b0; n++) @(posedge clk_i);
		for (c = 0; c < 200 && stp === 1'b0; c++) @(posedge clk_i);
		// the first timer tick may come up to one divider period late
		check("start width", {31'h0, c >= 2 * (div + 1) + 1 &&
			c <= 3 * (div + 1)}, 32'h1);
		for (n = 0; n < 200 && status !== 1'b1; n++) @(posedge clk_i);
		for (c = 0; c < 400 && sck !== 1'b1; c++) @(posedge clk_i);
		check("data delay", {31'h0, c >= 20 * (div + 1) &&
			c <= 24 * (div + 1) + 3}, 32'h1);
		for (n = 0; n < 20 && sck === 1'b1; n++) @(posedge clk_i);
		for (c = 0; c < 20 && sck !== 1'b1; c++) @(posedge clk_i);
		check("clock period", 32'(n + c), 32'(3 * (div + 1)));
		drain();
		rd(`CLD_OFF_STATUS, 32'h501, 32'h701);
		rd(`CLD_OFF_EVENT, 32'h4, 32'h4);
		$display("test state_machine done");

		wr(`CLD_OFF_EVENT, 32'hf);
		rd(`CLD_OFF_EVENT, 32'h0, 32'hf);
		push_word();
		wr(`CLD_OFF_CTRL, 32'h17);
		drain();
		err <= 1'b1;
		repeat (12) @(posedge clk_i);
		rd(`CLD_OFF_STATUS, 32'h608, 32'h70c);
		rd(`CLD_OFF_EVENT, 32'h8, 32'h8);
		err <= 1'b0;
		wr(`CLD_OFF_CTRL, 32'h17);
		for (n = 0; n < 50 && stp !== 1'b0; n++) @(posedge clk_i);
		check("restart pulse", {31'h0, stp}, 32'h0);
		$display("test error_restart done");
		check("setup fault", {31'h0, fault}, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
